/* hdl/gcva_pkg.sv */
// Purpose: Constants for the global line control and violation counter bank
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   Register index times four gives the byte address
package gcva_pkg;
  localparam int unsigned NCH    = 8;
  localparam int unsigned CW     = 16;
  localparam int unsigned ADDR_W = 12;

  // Register indices and their byte addresses
  localparam logic [7:0] IDX_SOURCE = 8'h82;
  localparam logic [7:0] IDX_SELECT = 8'h8C;
  localparam logic [7:0] IDX_CMD    = 8'h8D;
  localparam logic [7:0] IDX_BYTE   = 8'h8E;
  localparam logic [ADDR_W-1:0] ADDR_SOURCE = {2'h0, IDX_SOURCE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SELECT = {2'h0, IDX_SELECT, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CMD    = {2'h0, IDX_CMD, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_BYTE   = {2'h0, IDX_BYTE, 2'h0};

  // Field positions
  localparam int unsigned TX_SRC_BIT    = 7;
  localparam int unsigned TERM_SRC_BIT  = 6;
  localparam int unsigned CLR_ALL_BIT   = 4;
  localparam int unsigned LATCH_ALL_BIT = 3;
  localparam int unsigned BYTE_SEL_BIT  = 2;
  localparam int unsigned LATCH_ONE_BIT = 1;
  localparam int unsigned CLR_ONE_BIT   = 0;

  // Reset values
  localparam logic [7:0] SOURCE_RST = 8'h00;
  localparam logic [7:0] SELECT_RST = 8'h00;
  localparam logic [7:0] CMD_RST    = 8'h00;
  localparam logic [CW-1:0] COUNT_RST = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* hdl/gcva_cnt_if.sv */
// Purpose: Carries counter commands and held values between control and bank
// Assumes: One clock domain
// Notes:   held is the snapshot taken by a latch command
`timescale 1ns/10ps
interface gcva_cnt_if #(
  parameter int unsigned NCH = 8,
  parameter int unsigned CW  = 16
);
  logic [NCH-1:0] clear;
  logic [NCH-1:0] latch;
  logic [NCH-1:0] violation;
  logic [CW-1:0]  held [NCH];

  modport ctl  (output clear, output latch, output violation, input held);
  modport bank (input clear, input latch, input violation, output held);
endinterface

/* hdl/gcva_counter_bank.sv */
// Purpose: Per-channel violation counters with holding registers
// Assumes: Violation inputs are one-cycle pulses synchronous to aclk
// Notes:   Clear wins over count; counters wrap
`timescale 1ns/10ps
module gcva_counter_bank #(
  parameter int unsigned NCH = 8,
  parameter int unsigned CW  = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  gcva_cnt_if.bank cnt
);
  logic [CW-1:0] count      [NCH];
  logic [CW-1:0] next_count [NCH];
  logic [CW-1:0] held_q     [NCH];
  logic [CW-1:0] next_held  [NCH];

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    always_comb begin
      next_count[i] = count[i];
      next_held[i]  = held_q[i];
      if (cnt.clear[i]) begin
        next_count[i] = gcva_pkg::COUNT_RST; // RQ5 RQ10
      end else if (cnt.violation[i]) begin
        next_count[i] = count[i] + CW'(1); // RQ12
      end
      if (cnt.latch[i]) begin
        next_held[i] = count[i]; // RQ7 RQ9
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        count[i]  <= gcva_pkg::COUNT_RST;
        held_q[i] <= gcva_pkg::COUNT_RST;
      end else begin
        count[i]  <= next_count[i];
        held_q[i] <= next_held[i];
      end
    end

    assign cnt.held[i] = held_q[i];
  end
endmodule

/* hdl/gcva_top.sv */
// Purpose: Global line source select and violation counter access registers
// Assumes: AXI4-Lite slave, one write and one read outstanding at a time
// Notes:   Unmapped addresses answer SLVERR; byte read register ignores writes
`timescale 1ns/10ps
// Functional notes
// [RQ1] Tx enables follow the register bits if tx source is 0, the pins if 1.
// [RQ2] Rx termination follows channel bits if its source is 0, the pin if 1.
// [RQ3] Select bits 3:0 pick the channel for byte read, latch and clear.
// [RQ4] Code 0 selects no channel, code n+1 channel n; the field resets to 0.
// [RQ5] While the clear-all bit is 1 every counter is held at zero.
// [RQ6] Software holds clear-all at 1 for at least 1 us before writing 0.
// [RQ7] Latch-all at 1 copies every counter into its holding register.
// [RQ8] Spare select and command bits are plain storage that resets to 0.
// [RQ9] Latch-one at 1 copies the selected counter into its holding register.
// [RQ10] Clear-one at 1 zeroes the selected counter; software holds it 1 us.
// [RQ11] Byte read shows the low held byte if byte select is 0, the high if 1.
// [RQ12] Eight 16-bit counters count violations; code n+1 selects channel n.
module gcva_top #(
  parameter int unsigned NCH = gcva_pkg::NCH,
  parameter int unsigned CW  = gcva_pkg::CW
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [gcva_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [gcva_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [NCH-1:0]              line_code_violation,
  input  wire logic [NCH-1:0]              tx_enable_reg_bits,
  input  wire logic [NCH-1:0]              transmitter_on,
  input  wire logic [NCH-1:0]              rx_termination_reg_bits,
  input  wire logic                        rx_termination_pin,
  output logic [NCH-1:0]                   tx_enable,
  output logic [NCH-1:0]                   rx_termination
);
  gcva_cnt_if #(.NCH(NCH), .CW(CW)) cnt ();

  gcva_counter_bank #(.NCH(NCH), .CW(CW)) u_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cnt     (cnt)
  );

  logic [7:0]                  source_reg;
  logic [7:0]                  select_reg;
  logic [7:0]                  cmd_reg;
  logic [7:0]                  next_source;
  logic [7:0]                  next_select;
  logic [7:0]                  next_cmd;
  logic                        aw_have;
  logic                        w_have;
  logic [gcva_pkg::ADDR_W-1:0] aw_addr;
  logic [7:0]                  w_byte;
  logic                        w_lane0;
  logic                        next_aw_have;
  logic                        next_w_have;
  logic [gcva_pkg::ADDR_W-1:0] next_aw_addr;
  logic [7:0]                  next_w_byte;
  logic                        next_w_lane0;
  logic                        next_awready;
  logic                        next_wready;
  logic                        next_bvalid;
  logic [1:0]                  next_bresp;
  logic                        next_arready;
  logic                        next_rvalid;
  logic [31:0]                 next_rdata;
  logic [1:0]                  next_rresp;
  logic [NCH-1:0]              next_tx_enable;
  logic [NCH-1:0]              next_rx_term;
  logic [NCH-1:0]              chan_hit;
  logic [CW-1:0]               sel_held;
  logic [7:0]                  sel_byte;

  // Channel decode: code 0 selects nothing
  always_comb begin
    chan_hit = '0;
    sel_held = gcva_pkg::COUNT_RST;
    for (int i = 0; i < NCH; i++) begin
      if (select_reg[3:0] == 4'(i + 1)) begin // RQ3 RQ4 RQ12
        chan_hit[i] = 1'b1;
        sel_held    = cnt.held[i];
      end
    end
    if (cmd_reg[gcva_pkg::BYTE_SEL_BIT]) begin
      sel_byte = sel_held[15:8]; // RQ11
    end else begin
      sel_byte = sel_held[7:0]; // RQ11
    end
  end

  // Only the command bits reach the counters; upper bits are plain storage
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cnt.clear[i] = cmd_reg[gcva_pkg::CLR_ALL_BIT] // RQ5
                   | (cmd_reg[gcva_pkg::CLR_ONE_BIT] & chan_hit[i]); // RQ10
      cnt.latch[i] = cmd_reg[gcva_pkg::LATCH_ALL_BIT] // RQ7
                   | (cmd_reg[gcva_pkg::LATCH_ONE_BIT] & chan_hit[i]); // RQ9
    end
    cnt.violation = line_code_violation;
  end

  always_comb begin
    if (source_reg[gcva_pkg::TX_SRC_BIT]) begin
      next_tx_enable = transmitter_on; // RQ1
    end else begin
      next_tx_enable = tx_enable_reg_bits; // RQ1
    end
    if (source_reg[gcva_pkg::TERM_SRC_BIT]) begin
      next_rx_term = {NCH{rx_termination_pin}}; // RQ2
    end else begin
      next_rx_term = rx_termination_reg_bits; // RQ2
    end
  end

  // Write path: address and data taken in either order
  always_comb begin
    next_aw_have = aw_have;
    next_w_have  = w_have;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_source  = source_reg;
    next_select  = select_reg;
    next_cmd     = cmd_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_have = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_have  = 1'b1;
      next_w_byte  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_have && w_have && !s_axi_bvalid) begin
      next_aw_have = 1'b0;
      next_w_have  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = gcva_pkg::RESP_OKAY;
      case (aw_addr)
        gcva_pkg::ADDR_SOURCE: begin
          if (w_lane0) begin
            next_source = w_byte;
          end
        end
        gcva_pkg::ADDR_SELECT: begin
          if (w_lane0) begin
            next_select = w_byte; // RQ3 RQ8
          end
        end
        gcva_pkg::ADDR_CMD: begin
          if (w_lane0) begin
            next_cmd = w_byte; // RQ8
          end
        end
        gcva_pkg::ADDR_BYTE: begin
          next_bresp = gcva_pkg::RESP_OKAY;
        end
        default: begin
          next_bresp = gcva_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_have && !next_bvalid;
    next_wready  = !next_w_have && !next_bvalid;
  end

  // Read path
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = gcva_pkg::RESP_OKAY;
      case (s_axi_araddr)
        gcva_pkg::ADDR_SOURCE: next_rdata = {24'h000000, source_reg};
        gcva_pkg::ADDR_SELECT: next_rdata = {24'h000000, select_reg}; // RQ8
        gcva_pkg::ADDR_CMD:    next_rdata = {24'h000000, cmd_reg}; // RQ8
        gcva_pkg::ADDR_BYTE:   next_rdata = {24'h000000, sel_byte}; // RQ11
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = gcva_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_reg     <= gcva_pkg::SOURCE_RST;
      select_reg     <= gcva_pkg::SELECT_RST; // RQ4 RQ8
      cmd_reg        <= gcva_pkg::CMD_RST; // RQ8
      aw_have        <= 1'b0;
      w_have         <= 1'b0;
      aw_addr        <= '0;
      w_byte         <= 8'h00;
      w_lane0        <= 1'b0;
      s_axi_awready  <= 1'b0;
      s_axi_wready   <= 1'b0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= gcva_pkg::RESP_OKAY;
      s_axi_arready  <= 1'b0;
      s_axi_rvalid   <= 1'b0;
      s_axi_rdata    <= 32'h00000000;
      s_axi_rresp    <= gcva_pkg::RESP_OKAY;
      tx_enable      <= '0;
      rx_termination <= '0;
    end else begin
      source_reg     <= next_source;
      select_reg     <= next_select;
      cmd_reg        <= next_cmd;
      aw_have        <= next_aw_have;
      w_have         <= next_w_have;
      aw_addr        <= next_aw_addr;
      w_byte         <= next_w_byte;
      w_lane0        <= next_w_lane0;
      s_axi_awready  <= next_awready;
      s_axi_wready   <= next_wready;
      s_axi_bvalid   <= next_bvalid;
      s_axi_bresp    <= next_bresp;
      s_axi_arready  <= next_arready;
      s_axi_rvalid   <= next_rvalid;
      s_axi_rdata    <= next_rdata;
      s_axi_rresp    <= next_rresp;
      tx_enable      <= next_tx_enable;
      rx_termination <= next_rx_term;
    end
  end
endmodule

/* tb/gcva_top_sva.sv */
// Purpose: Port-level checks for the violation counter register bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Attached by bind from the testbench top file
`timescale 1ns/10ps
module gcva_top_sva #(
  parameter int unsigned NCH = 8
) (
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           s_axi_awvalid,
  input wire logic           s_axi_awready,
  input wire logic           s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic [1:0]     s_axi_bresp,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic [31:0]    s_axi_rdata,
  input wire logic           s_axi_rvalid,
  input wire logic           s_axi_rready,
  input wire logic [NCH-1:0] tx_enable_reg_bits,
  input wire logic [NCH-1:0] transmitter_on,
  input wire logic [NCH-1:0] rx_termination_reg_bits,
  input wire logic           rx_termination_pin,
  input wire logic [NCH-1:0] tx_enable,
  input wire logic [NCH-1:0] rx_termination
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tx_source: assert property ($past(aresetn) |->
    tx_enable == $past(transmitter_on) || tx_enable == $past(tx_enable_reg_bits))
    else $error("tx enable follows neither source");
  a_term_source: assert property ($past(aresetn) |->
    rx_termination == {NCH{$past(rx_termination_pin)}} ||
    rx_termination == $past(rx_termination_reg_bits))
    else $error("termination follows neither source");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_write_busy: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h000000) else $error("upper read bits set");
endmodule

/* tb/tb.sv */
// Purpose: Self-checking bench for the violation counter register bank
// Assumes: AXI4-Lite master tasks, 100 MHz clock
// Notes:   Counts per channel are 3 + 37 * channel
`timescale 1ns/10ps
module tb;
  logic                        aclk = 1'h0;
  logic                        aresetn = 1'h0;
  logic [gcva_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
  logic [gcva_pkg::ADDR_W-1:0] s_axi_araddr = '0;
  logic [31:0]                 s_axi_wdata = '0;
  logic [3:0]                  s_axi_wstrb = 4'hF;
  logic                        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic                        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic                        s_axi_rready = 1'h0, rx_termination_pin = 1'h0;
  logic [7:0]                  line_code_violation = '0, transmitter_on = '0;
  logic [7:0]                  tx_enable_reg_bits = '0;
  logic [7:0]                  rx_termination_reg_bits = '0;
  wire logic                   s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire logic                   s_axi_arready, s_axi_rvalid;
  wire logic [1:0]             s_axi_bresp, s_axi_rresp;
  wire logic [31:0]            s_axi_rdata;
  wire logic [7:0]             tx_enable, rx_termination;
  int                          n_errors = 0;
  int                          compares = 0;
  localparam logic [11:0] SRC = gcva_pkg::ADDR_SOURCE;
  localparam logic [11:0] SEL = gcva_pkg::ADDR_SELECT;
  localparam logic [11:0] CMD = gcva_pkg::ADDR_CMD;
  localparam logic [11:0] BYT = gcva_pkg::ADDR_BYTE;
  always #5 aclk = ~aclk;
  gcva_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .line_code_violation, .tx_enable_reg_bits, .transmitter_on,
    .rx_termination_reg_bits, .rx_termination_pin, .tx_enable, .rx_termination);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] e = 2'h0);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) begin
        chk({30'h0, s_axi_bresp}, {30'h0, e});
        s_axi_bready <= 1'h0;
        break;
      end
    end
    if (n == 50) n_errors++;
  endtask
  task automatic rr(input logic [11:0] a, input logic [7:0] e,
                    input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) begin
        chk(s_axi_rdata, {24'h000000, e});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'h0;
        break;
      end
    end
    if (n == 50) n_errors++;
  endtask
  task automatic rb(input int c, input logic hi, input logic [7:0] e);
    wr(SEL, 8'(c + 1));
    wr(CMD, hi ? 8'h04 : 8'h00);
    rr(BYT, e);
  endtask
  task automatic pulse(input logic [7:0] m, input int k);
    for (int i = 0; i < k; i++) begin
      @(posedge aclk);
      for (int c = 0; c < 8; c++) begin
        line_code_violation[c] <= m[c] && (i < 3 + 37 * c);
      end
    end
    @(posedge aclk);
    line_code_violation <= 8'h00;
  endtask
  task automatic t_regs;
    rr(SRC, 8'h00);
    rr(SEL, 8'h00);
    rr(CMD, 8'h00);
    rr(BYT, 8'h00);
    wr(SEL, 8'hF5);
    rr(SEL, 8'hF5);
    s_axi_wstrb <= 4'h0;
    wr(SEL, 8'h3A);
    s_axi_wstrb <= 4'hF;
    rr(SEL, 8'hF5);
    wr(CMD, 8'hE0);
    rr(CMD, 8'hE0);
    wr(CMD, 8'h00);
    wr(BYT, 8'h55);
    rr(BYT, 8'h00);
    wr(12'h004, 8'h01, 2'h2);
    rr(12'h004, 8'h00, 2'h2);
    $display("test regs done");
  endtask
  task automatic t_source;
    tx_enable_reg_bits <= 8'h5A;
    transmitter_on <= 8'hC3;
    rx_termination_reg_bits <= 8'h3C;
    rx_termination_pin <= 1'h1;
    wr(SRC, 8'h80);
    repeat (3) @(posedge aclk);
    chk({24'h0, tx_enable}, 32'h000000C3);
    chk({24'h0, rx_termination}, 32'h0000003C);
    wr(SRC, 8'h40);
    repeat (3) @(posedge aclk);
    chk({24'h0, tx_enable}, 32'h0000005A);
    chk({24'h0, rx_termination}, 32'h000000FF);
    rx_termination_pin <= 1'h0;
    repeat (3) @(posedge aclk);
    chk({24'h0, rx_termination}, 32'h00000000);
    rr(SRC, 8'h40);
    $display("test source done");
  endtask
  task automatic t_count;
    pulse(8'hFF, 262);
    wr(CMD, 8'h08);
    wr(CMD, 8'h00);
    for (int c = 0; c < 8; c++) rb(c, 1'h0, 8'(3 + 37 * c));
    wr(SEL, 8'h09);
    rr(BYT, 8'h00);
    rb(7, 1'h1, 8'h01);
    wr(SEL, 8'h00);
    rr(BYT, 8'h00);
    pulse(8'h03, 5);
    wr(SEL, 8'h01);
    wr(CMD, 8'h02);
    wr(CMD, 8'h00);
    rb(0, 1'h0, 8'h06);
    rb(1, 1'h0, 8'h28);
    wr(SEL, 8'h02);
    wr(CMD, 8'h01);
    repeat (100) @(posedge aclk);
    wr(CMD, 8'h08);
    wr(CMD, 8'h00);
    rb(1, 1'h0, 8'h00);
    rb(0, 1'h0, 8'h06);
    wr(CMD, 8'h10);
    repeat (100) @(posedge aclk);
    wr(CMD, 8'h08);
    wr(CMD, 8'h00);
    for (int c = 0; c < 8; c++) rb(c, 1'h0, 8'h00);
    $display("test counters done");
  endtask
  task automatic results;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_errors++;
    results();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_source();
    t_count();
    results();
  end
endmodule
bind gcva_top gcva_top_sva #(.NCH(NCH)) chk_u (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .tx_enable_reg_bits, .transmitter_on,
  .rx_termination_reg_bits, .rx_termination_pin, .tx_enable, .rx_termination);
